// ---- design/scu_defs.vh ----
// Offsets, field positions, reset values and counts of the system control unit.
`ifndef SCU_DEFS_VH
`define SCU_DEFS_VH
`define SCU_OFF_BOOT      8'h00
`define SCU_OFF_RSTCTL    8'h04
`define SCU_OFF_LOWPWR    8'h08
`define SCU_OFF_CLKCTL    8'h0c
`define SCU_OFF_DBGPIN    8'h14
`define SCU_OFF_IRQSTAT   8'h2c
`define SCU_OFF_IRQMASK   8'h30
`define SCU_BIT_LPWR_FLAG 31
`define SCU_BIT_WDOG_FLAG 30
`define SCU_BIT_IWDG_FLAG 29
`define SCU_BIT_SFT_FLAG  28
`define SCU_BIT_POR_FLAG  27
`define SCU_BIT_PIN_FLAG  26
`define SCU_BIT_EXT_FLAG  25
`define SCU_BIT_FLAG_CLR  24
`define SCU_BIT_EXT_EN    1
`define SCU_BIT_SFT_TRIG  0
`define SCU_FLAGS_HI      31
`define SCU_FLAGS_LO      25
`define SCU_FLAGS_POR     7'h04
`define SCU_BIT_DIV_HI_H  15
`define SCU_BIT_DIV_HI_L  12
`define SCU_BIT_DIV_LO_H  11
`define SCU_BIT_DIV_LO_L  8
`define SCU_BIT_PLL_RDY   6
`define SCU_BIT_PLL_ON    5
`define SCU_BIT_OSC_RDY   4
`define SCU_BIT_OSC_BYP   3
`define SCU_BIT_OSC_ON    2
`define SCU_LPWR_SLEEP    2'h0
`define SCU_LPWR_STOP     2'h1
`define SCU_LPWR_STANDBY  2'h3
`define SCU_RST_LOWPWR    2'h0
`define SCU_RST_DIV       4'h0
`define SCU_RST_CLKBITS   3'h0
`define SCU_RST_DBGPIN    5'h00
`define SCU_RST_MASK      3'h0
`define SCU_BOOT_EDGE     3'h4
`define SCU_IRQ_PLL       0
`define SCU_IRQ_OSC       1
`define SCU_IRQ_REFUSED   2
`endif

// ---- design/scu_clk_div.v ----
// Flash serial clock divider producing one tick every (divide + 1) system clocks.
`timescale 1ns/1ps
`include "scu_defs.vh"
module scu_clk_div (
   input  wire       i_clk,
   input  wire       i_rst,
   input  wire [3:0] i_div,
   output reg        o_tick
);
   reg [3:0] cnt_r;

   // A new divide value takes effect at once; a value at or below the current count
   // ends the period at the next clock, so one shortened flash clock period can appear.
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_r  <= `SCU_RST_DIV;
         o_tick <= 1'b0;
      end else if (cnt_r >= i_div) begin
         cnt_r  <= 4'h0;
         o_tick <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 4'h1;
         o_tick <= 1'b0;
      end
   end
endmodule // scu_clk_div

// ---- design/scu_top.v ----
// System control unit: boot latch, reset causes, power, clock and debug pin control.
// Behaviour
// - Primary boot pin low selects main flash.
// - Primary high, secondary low selects boot ROM.
// - Latch boot pins at fourth edge after reset.
// - Flags 31..28: lowpower, watchdog, indep watchdog, software.
// - Flags 27..25: power-on, reset pin, external logic.
// - Writing bit 24 clears all seven flags.
// - Bit 1 gates external logic reset requests.
// - Writing bit 0 triggers a software reset.
// - Low power field selects sleep, stop, standby.
// - Flash clock is system clock over (div+1).
// - Bit 5 enables PLL; bit 6 reports ready.
// - Bit 2 enables oscillator; bit 4 reports ready.
// - Bit 3 bypasses the external oscillator.
// - Bits 4..0 make debug pins user I/O.
`timescale 1ns/1ps
`include "scu_defs.vh"
module scu_top (
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire        i_por,
   input  wire [7:0]  i_addr,
   input  wire [31:0] i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [31:0] o_rdata,
   input  wire        i_primary_boot_pin,
   input  wire        i_secondary_boot_pin,
   input  wire        i_lowpower_reset_evt,
   input  wire        i_watchdog_reset_evt,
   input  wire        i_indep_watchdog_reset_evt,
   input  wire        i_pin_reset_evt,
   input  wire        i_extlogic_reset_req,
   input  wire        i_pll_ready,
   input  wire        i_ext_osc_ready,
   output reg         o_boot_latched,
   output reg         o_boot_from_flash,
   output reg         o_boot_from_rom,
   output reg         o_software_reset_req,
   output reg         o_extlogic_reset_req,
   output reg  [1:0]  o_low_power_field,
   output reg         o_pll_enable,
   output reg         o_ext_osc_enable,
   output reg         o_ext_osc_bypass,
   output reg  [4:0]  o_debug_pin_user,
   output wire        o_flash_sclk_tick,
   output reg         o_irq
);
   // Synchronisers for pins and for signals from other clock sources.
   reg [1:0] primary_boot_pin_sync_r;
   reg [1:0] secondary_boot_pin_sync_r;
   reg [1:0] pll_sync_r;
   reg [1:0] osc_sync_r;
   reg [1:0] ext_sync_r;
   reg       pll_prev_r;
   reg       osc_prev_r;
   reg       ext_prev_r;

   // Cause synchronisers live in the power-on domain so that the cause of a
   // chip reset is still seen once that reset has been released.
   reg [1:0] lp_sync_r;
   reg [1:0] wd_sync_r;
   reg [1:0] iw_sync_r;
   reg [1:0] pin_sync_r;

   reg [2:0] boot_cnt_r;
   reg [1:0] boot_field_r;
   reg [6:0] flags_r;
   reg [6:0] flags_nxt;
   reg       ext_en_r;
   reg [3:0] div_hi_r;
   reg [3:0] div_lo_r;
   reg [2:0] irq_stat_r;
   reg [2:0] irq_stat_nxt;
   reg [2:0] irq_mask_r;
   reg [31:0] rdata_nxt;

   wire wr_rst  = i_wr && (i_addr == `SCU_OFF_RSTCTL);
   wire wr_lp   = i_wr && (i_addr == `SCU_OFF_LOWPWR);
   wire wr_clk  = i_wr && (i_addr == `SCU_OFF_CLKCTL);
   wire wr_dbg  = i_wr && (i_addr == `SCU_OFF_DBGPIN);
   wire wr_mask = i_wr && (i_addr == `SCU_OFF_IRQMASK);
   wire rd_stat = i_rd && (i_addr == `SCU_OFF_IRQSTAT);

   wire sft_trig  = wr_rst && i_wdata[`SCU_BIT_SFT_TRIG];
   wire ext_rise  = ext_sync_r[1] && !ext_prev_r;
   wire ext_go    = ext_rise && ext_en_r;
   wire ext_block = ext_rise && !ext_en_r;
   wire pll_rise  = pll_sync_r[1] && !pll_prev_r;
   wire osc_rise  = osc_sync_r[1] && !osc_prev_r;

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         primary_boot_pin_sync_r <= 2'h0;
         secondary_boot_pin_sync_r <= 2'h0;
         pll_sync_r   <= 2'h0;
         osc_sync_r   <= 2'h0;
         ext_sync_r   <= 2'h0;
         pll_prev_r   <= 1'b0;
         osc_prev_r   <= 1'b0;
         ext_prev_r   <= 1'b0;
      end else begin
         primary_boot_pin_sync_r <= {primary_boot_pin_sync_r[0], i_primary_boot_pin};
         secondary_boot_pin_sync_r <= {secondary_boot_pin_sync_r[0], i_secondary_boot_pin};
         pll_sync_r   <= {pll_sync_r[0], i_pll_ready};
         osc_sync_r   <= {osc_sync_r[0], i_ext_osc_ready};
         ext_sync_r   <= {ext_sync_r[0], i_extlogic_reset_req};
         pll_prev_r   <= pll_sync_r[1];
         osc_prev_r   <= osc_sync_r[1];
         ext_prev_r   <= ext_sync_r[1];
      end
   end

   always @(posedge i_clk or posedge i_por) begin
      if (i_por) begin
         lp_sync_r  <= 2'h0;
         wd_sync_r  <= 2'h0;
         iw_sync_r  <= 2'h0;
         pin_sync_r <= 2'h0;
      end else begin
         lp_sync_r  <= {lp_sync_r[0], i_lowpower_reset_evt};
         wd_sync_r  <= {wd_sync_r[0], i_watchdog_reset_evt};
         iw_sync_r  <= {iw_sync_r[0], i_indep_watchdog_reset_evt};
         pin_sync_r <= {pin_sync_r[0], i_pin_reset_evt};
      end
   end

   // Boot straps are static, so the two synchroniser cycles fall well inside
   // the four-edge window and the latched value is the level at the pins.
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         boot_cnt_r        <= 3'h0;
         boot_field_r      <= 2'h0;
         o_boot_latched    <= 1'b0;
         o_boot_from_flash <= 1'b0;
         o_boot_from_rom   <= 1'b0;
      end else if (boot_cnt_r != `SCU_BOOT_EDGE) begin
         boot_cnt_r <= boot_cnt_r + 3'h1;
         if (boot_cnt_r == `SCU_BOOT_EDGE - 3'h1) begin
            boot_field_r      <= {secondary_boot_pin_sync_r[1], primary_boot_pin_sync_r[1]};
            o_boot_latched    <= 1'b1;
            o_boot_from_flash <= !primary_boot_pin_sync_r[1];
            o_boot_from_rom   <= primary_boot_pin_sync_r[1] && !secondary_boot_pin_sync_r[1];
         end
      end
   end

   // A cause that arrives with the clear write still lands: set wins.
   always @* begin
      flags_nxt = flags_r;
      if (wr_rst && i_wdata[`SCU_BIT_FLAG_CLR]) begin
         flags_nxt = 7'h00;
      end
      flags_nxt[6] = flags_nxt[6] | lp_sync_r[1];
      flags_nxt[5] = flags_nxt[5] | wd_sync_r[1];
      flags_nxt[4] = flags_nxt[4] | iw_sync_r[1];
      flags_nxt[3] = flags_nxt[3] | sft_trig;
      flags_nxt[1] = flags_nxt[1] | pin_sync_r[1];
      flags_nxt[0] = flags_nxt[0] | ext_go;
   end

   // Only power-on reset touches the flags; the power-on flag is its constant.
   always @(posedge i_clk or posedge i_por) begin
      if (i_por) begin
         flags_r <= `SCU_FLAGS_POR;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ext_en_r             <= 1'b0;
         o_software_reset_req <= 1'b0;
         o_extlogic_reset_req <= 1'b0;
      end else begin
         if (wr_rst) begin
            ext_en_r <= i_wdata[`SCU_BIT_EXT_EN];
         end
         o_software_reset_req <= sft_trig;
         o_extlogic_reset_req <= ext_go;
      end
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_low_power_field <= `SCU_RST_LOWPWR;
         div_hi_r          <= `SCU_RST_DIV;
         div_lo_r          <= `SCU_RST_DIV;
         o_pll_enable      <= 1'b0;
         o_ext_osc_enable  <= 1'b0;
         o_ext_osc_bypass  <= 1'b0;
         o_debug_pin_user  <= `SCU_RST_DBGPIN;
         irq_mask_r        <= `SCU_RST_MASK;
      end else begin
         if (wr_lp) begin
            // The unlisted code 10 is stored as written and treated as sleep.
            o_low_power_field <= i_wdata[1:0];
         end
         if (wr_clk) begin
            div_hi_r         <= i_wdata[`SCU_BIT_DIV_HI_H:`SCU_BIT_DIV_HI_L];
            div_lo_r         <= i_wdata[`SCU_BIT_DIV_LO_H:`SCU_BIT_DIV_LO_L];
            o_pll_enable     <= i_wdata[`SCU_BIT_PLL_ON];
            o_ext_osc_enable <= i_wdata[`SCU_BIT_OSC_ON];
            o_ext_osc_bypass <= i_wdata[`SCU_BIT_OSC_BYP];
         end
         if (wr_dbg) begin
            o_debug_pin_user <= i_wdata[4:0];
         end
         if (wr_mask) begin
            irq_mask_r <= i_wdata[2:0];
         end
      end
   end

   // Only the high divider field drives the divider; the low field is kept
   // for software, which must write both with the same value.
   scu_clk_div u_clk_div (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_div  (div_hi_r),
      .o_tick (o_flash_sclk_tick)
   );

   always @* begin
      irq_stat_nxt = irq_stat_r;
      if (rd_stat) begin
         irq_stat_nxt = 3'h0;
      end
      irq_stat_nxt[`SCU_IRQ_PLL]     = irq_stat_nxt[`SCU_IRQ_PLL] | pll_rise;
      irq_stat_nxt[`SCU_IRQ_OSC]     = irq_stat_nxt[`SCU_IRQ_OSC] | osc_rise;
      irq_stat_nxt[`SCU_IRQ_REFUSED] = irq_stat_nxt[`SCU_IRQ_REFUSED] | ext_block;
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_stat_r <= 3'h0;
         o_irq      <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         o_irq      <= |(irq_stat_nxt & irq_mask_r);
      end
   end

   always @* begin
      rdata_nxt = 32'h0000_0000;
      if (i_rd) begin
         case (i_addr)
            `SCU_OFF_BOOT: begin
               rdata_nxt[1:0] = boot_field_r;
            end
            `SCU_OFF_RSTCTL: begin
               rdata_nxt[`SCU_FLAGS_HI:`SCU_FLAGS_LO] = flags_r;
               rdata_nxt[`SCU_BIT_EXT_EN]             = ext_en_r;
            end
            `SCU_OFF_LOWPWR: begin
               rdata_nxt[1:0] = o_low_power_field;
            end
            `SCU_OFF_CLKCTL: begin
               rdata_nxt[`SCU_BIT_DIV_HI_H:`SCU_BIT_DIV_HI_L] = div_hi_r;
               rdata_nxt[`SCU_BIT_DIV_LO_H:`SCU_BIT_DIV_LO_L] = div_lo_r;
               rdata_nxt[`SCU_BIT_PLL_RDY] = pll_sync_r[1];
               rdata_nxt[`SCU_BIT_PLL_ON]  = o_pll_enable;
               rdata_nxt[`SCU_BIT_OSC_RDY] = osc_sync_r[1];
               rdata_nxt[`SCU_BIT_OSC_BYP] = o_ext_osc_bypass;
               rdata_nxt[`SCU_BIT_OSC_ON]  = o_ext_osc_enable;
            end
            `SCU_OFF_DBGPIN: begin
               rdata_nxt[4:0] = o_debug_pin_user;
            end
            `SCU_OFF_IRQSTAT: begin
               rdata_nxt[2:0] = irq_stat_r;
            end
            `SCU_OFF_IRQMASK: begin
               rdata_nxt[2:0] = irq_mask_r;
            end
            default: begin
               rdata_nxt = 32'h0000_0000;
            end
         endcase
      end
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 32'h0000_0000;
      end else begin
         o_rdata <= rdata_nxt;
      end
   end
endmodule // scu_top

// ---- tb/scu_top_chk.sv ----
// Concurrent checks on the ports of the system control unit.
`timescale 1ns/1ps
`include "scu_defs.vh"
module scu_top_chk (
   input logic        i_clk,
   input logic        i_rst,
   input logic [7:0]  i_addr,
   input logic [31:0] i_wdata,
   input logic        i_wr,
   input logic        i_rd,
   input logic [31:0] o_rdata,
   input logic        i_primary_boot_pin,
   input logic        i_secondary_boot_pin,
   input logic        o_boot_latched,
   input logic        o_boot_from_flash,
   input logic        o_boot_from_rom,
   input logic        o_software_reset_req,
   input logic [1:0]  o_low_power_field,
   input logic        o_pll_enable,
   input logic        o_ext_osc_enable,
   input logic        o_ext_osc_bypass,
   input logic [4:0]  o_debug_pin_user,
   input logic        o_flash_sclk_tick
);
   logic [3:0] gap_r;
   logic [3:0] div_r;
   logic [1:0] tk_r;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // The period is judged only from the third tick after a divider write, as the first may be partial.
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         gap_r <= 4'h0;
         div_r <= 4'h0;
         tk_r  <= 2'h0;
      end else begin
         gap_r <= o_flash_sclk_tick ? 4'h0 : gap_r + 4'h1;
         if (i_wr && i_addr == `SCU_OFF_CLKCTL) begin
            div_r <= i_wdata[15:12];
            tk_r  <= 2'h0;
         end else if (o_flash_sclk_tick && tk_r != 2'h2) begin
            tk_r <= tk_r + 2'h1;
         end
      end
   end
   boot_edge_a: assert property ($fell(i_rst) |-> !o_boot_latched [*4] ##1 o_boot_latched)
      else $error("boot latch not on fourth edge");
   boot_map_a: assert property ($rose(o_boot_latched) |-> o_boot_from_flash == !i_primary_boot_pin
      && o_boot_from_rom == (i_primary_boot_pin && !i_secondary_boot_pin)) else $error("boot source wrong");
   boot_hold_a: assert property (o_boot_latched && $past(o_boot_latched) |->
      $stable(o_boot_from_flash) && $stable(o_boot_from_rom)) else $error("boot source moved");
   boot_read_a: assert property (i_rd && i_addr == `SCU_OFF_BOOT && o_boot_latched |=>
      o_rdata[0] == !o_boot_from_flash && o_rdata[31:2] == 30'h0) else $error("boot field read wrong");
   sw_reset_a: assert property (i_wr && i_addr == `SCU_OFF_RSTCTL && i_wdata[0] |=>
      o_software_reset_req ##1 !o_software_reset_req) else $error("software reset pulse wrong");
   lowpwr_write_a: assert property (i_wr && i_addr == `SCU_OFF_LOWPWR |=>
      o_low_power_field == $past(i_wdata[1:0])) else $error("low power field wrong");
   clk_bits_a: assert property (i_wr && i_addr == `SCU_OFF_CLKCTL |=>
      {o_pll_enable, o_ext_osc_bypass, o_ext_osc_enable} == $past({i_wdata[5], i_wdata[3], i_wdata[2]}))
      else $error("clock control bits wrong");
   dbg_pins_a: assert property (i_wr && i_addr == `SCU_OFF_DBGPIN |=>
      o_debug_pin_user == $past(i_wdata[4:0])) else $error("debug pin config wrong");
   tick_period_a: assert property (o_flash_sclk_tick && tk_r == 2'h2 |-> gap_r == div_r)
      else $error("flash clock tick period wrong");
endmodule // scu_top_chk

// ---- tb/tb_scu_top.sv ----
// Self-checking bench for the system control unit.
`timescale 1ns/1ps
`include "scu_defs.vh"
module tb_scu_top;
   logic        i_clk = 0, i_rst = 1, i_por = 1, i_wr = 0, i_rd = 0, s;
   logic [7:0]  i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0, o_rdata, v;
   logic        i_primary_boot_pin = 0, i_secondary_boot_pin = 0, i_extlogic_reset_req = 0;
   logic        i_pll_ready = 0, i_ext_osc_ready = 0;
   logic [3:0]  ev = 4'h0;
   logic        o_boot_latched, o_boot_from_flash, o_boot_from_rom, o_software_reset_req;
   logic        o_extlogic_reset_req, o_pll_enable, o_ext_osc_enable, o_ext_osc_bypass, o_flash_sclk_tick, o_irq;
   logic [1:0]  o_low_power_field;
   logic [4:0]  o_debug_pin_user;
   int          mismatches = 0, checked = 0, n;
   scu_top scu_top_i (.*, .i_lowpower_reset_evt(ev[3]), .i_watchdog_reset_evt(ev[2]),
      .i_indep_watchdog_reset_evt(ev[1]), .i_pin_reset_evt(ev[0]));
   always #10 i_clk = ~i_clk;
   task automatic wrap_up;
      if (mismatches == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      i_rd <= 1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 0;
      #1 v = o_rdata;
   endtask
   // Waits for the boot latch under a bound; a missing latch ends the run.
   task automatic reset(input logic por);
      i_rst <= 1;
      i_por <= por;
      repeat (16) @(posedge i_clk);
      i_rst <= 0;
      i_por <= 0;
      n = 0;
      while (o_boot_latched !== 1'b1 && n < 10) begin
         @(posedge i_clk);
         #1 n++;
      end
      if (n == 10) begin
         mismatches++;
         wrap_up;
      end
   endtask
   task automatic watch;
      s = 0;
      repeat (8) begin
         @(posedge i_clk);
         #1 s = s | o_extlogic_reset_req;
      end
   endtask
   task automatic boot_scn;
      for (int k = 0; k < 4; k++) begin
         {i_secondary_boot_pin, i_primary_boot_pin} <= k[1:0];
         reset(k == 0);
         chk(o_boot_from_flash, !k[0]);
         chk(o_boot_from_rom, k[0] & !k[1]);
         // Straps stay put until the latch checker has sampled them at the rise.
         repeat (2) @(posedge i_clk);
         {i_secondary_boot_pin, i_primary_boot_pin} <= ~k[1:0];
         wr(`SCU_OFF_BOOT, 32'h3);
         rd(`SCU_OFF_BOOT);
         chk(v, {30'h0, k[1:0]});
      end
   endtask
   task automatic flags_scn;
      int b[4] = '{26, 29, 30, 31};
      reset(1);
      rd(`SCU_OFF_RSTCTL);
      chk(v, 32'h0800_0000);
      wr(`SCU_OFF_RSTCTL, 32'h0100_0000);
      for (int k = 0; k < 4; k++) begin
         ev[k] <= 1;
         repeat (2) @(posedge i_clk);
         ev[k] <= 0;
         repeat (4) @(posedge i_clk);
         rd(`SCU_OFF_RSTCTL);
         chk(v, 32'h1 << b[k]);
         wr(`SCU_OFF_RSTCTL, 32'h0100_0000);
      end
      wr(`SCU_OFF_RSTCTL, 32'h1);
      #1 chk(o_software_reset_req, 1);
      @(posedge i_clk);
      #1 chk(o_software_reset_req, 0);
      // Let the pulse checker finish before the next reset disables it.
      repeat (2) @(posedge i_clk);
      reset(0);
      rd(`SCU_OFF_RSTCTL);
      chk(v, 32'h1000_0000);
      wr(`SCU_OFF_RSTCTL, 32'h0100_0000);
      rd(`SCU_OFF_RSTCTL);
      chk(v, 32'h0);
   endtask
   task automatic ext_scn;
      wr(`SCU_OFF_IRQMASK, 32'h7);
      i_extlogic_reset_req <= 1;
      watch;
      chk(s, 0);
      chk(o_irq, 1);
      rd(`SCU_OFF_IRQSTAT);
      chk(v, 32'h4);
      chk(o_irq, 0);
      rd(`SCU_OFF_RSTCTL);
      chk(v, 32'h0);
      i_extlogic_reset_req <= 0;
      wr(`SCU_OFF_RSTCTL, 32'h2);
      i_extlogic_reset_req <= 1;
      watch;
      chk(s, 1);
      rd(`SCU_OFF_RSTCTL);
      chk(v, 32'h0200_0002);
   endtask
   task automatic regs_scn;
      logic [1:0] lp[3] = '{2'h0, 2'h1, 2'h3};
      for (int k = 0; k < 3; k++) begin
         wr(`SCU_OFF_LOWPWR, {30'h0, lp[k]});
         rd(`SCU_OFF_LOWPWR);
         chk(v, {30'h0, lp[k]});
         chk(o_low_power_field, lp[k]);
      end
      wr(`SCU_OFF_CLKCTL, 32'h332c);
      #1 chk({o_pll_enable, o_ext_osc_bypass, o_ext_osc_enable}, 3'h7);
      wr(`SCU_OFF_IRQMASK, 32'h0);
      i_pll_ready <= 1;
      i_ext_osc_ready <= 1;
      repeat (4) @(posedge i_clk);
      rd(`SCU_OFF_CLKCTL);
      chk(v, 32'h337c);
      chk(o_irq, 0);
      rd(`SCU_OFF_IRQSTAT);
      chk(v, 32'h3);
      n = 0;
      repeat (32) begin
         @(posedge i_clk);
         #1 n += o_flash_sclk_tick;
      end
      chk(n, 8);
      wr(`SCU_OFF_CLKCTL, 32'hff00);
      repeat (60) @(posedge i_clk);
      wr(`SCU_OFF_DBGPIN, 32'h15);
      #1 chk(o_debug_pin_user, 5'h15);
      rd(`SCU_OFF_DBGPIN);
      chk(v, 32'h15);
      rd(8'h10);
      chk(v, 32'h0);
   endtask
   initial begin
      boot_scn;
      flags_scn;
      ext_scn;
      regs_scn;
      wrap_up;
   end
endmodule // tb_scu_top
bind scu_top scu_top_chk scu_top_chk_i (.*);
